/* File: scp_pkg.sv */
// Constants and types for the serial command port front end
package scp_pkg;
	localparam int SCP_BYTE_W = 8;
	localparam int SCP_FIFO_DEPTH = 32;
	localparam int SCP_PTR_W = 5;
	localparam logic [2:0] SCP_BITCNT_RST = 3'h0;
	localparam logic [2:0] SCP_BITCNT_LAST = 3'h7;
	localparam logic [7:0] SCP_BYTE_RST = 8'h00;
	localparam logic [7:0] SCP_IDLE_DATA = 8'hFF;
	localparam logic [1:0] SCP_SYNC_RST = 2'h0;
	localparam logic [1:0] SCP_PIN_RST = 2'h3;

	typedef enum logic [0:0] {
		SCP_IDLE = 1'b0,
		SCP_XFER = 1'b1
	} scp_state_t;

	typedef struct packed {
		scp_state_t state;
		logic [1:0] sck_sync;
		logic [1:0] cs_sync;
		logic [1:0] si_sync;
		logic [1:0] edge_sync;
		logic sck_prev;
		logic [2:0] in_cnt;
		logic [7:0] in_shift;
		logic [2:0] out_cnt;
		logic [7:0] out_shift;
		logic so;
		logic so_oe_n;
		logic busy_n;
		logic wr_valid;
		logic [7:0] wr_data;
		logic reply_rdy;
	} scp_regs_t;
endpackage

/* File: scp_fifo.sv */
// Parameterised FIFO with valid/ready on both sides
module scp_fifo
	import scp_pkg::*;
#(
	parameter int WIDTH = SCP_BYTE_W,
	parameter int DEPTH = SCP_FIFO_DEPTH,
	parameter int PW = SCP_PTR_W
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_ptr_reg;
	logic [PW:0] rd_ptr_reg;
	logic [WIDTH-1:0] rd_data_reg;
	logic rd_valid_reg;
	logic empty;
	logic full;
	logic do_wr;
	logic do_rd;

	assign empty = wr_ptr_reg == rd_ptr_reg;
	assign full = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) && (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
	assign in_ready = !full;
	assign do_wr = in_valid && !full;
	// Refill output register when it is empty or being drained
	assign do_rd = !empty && (!rd_valid_reg || out_ready);
	assign out_valid = rd_valid_reg;
	assign out_data = rd_data_reg;

	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wr_ptr_reg[PW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
		end else begin
			if (do_wr) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (do_rd) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				rd_data_reg <= mem[rd_ptr_reg[PW-1:0]];
				rd_valid_reg <= 1'b1;
			end else if (out_ready) begin
				rd_valid_reg <= 1'b0;
			end
		end
	end
endmodule

/* File: scp_port.sv */
// Serial command port front end with edge select and receive FIFO
module scp_port
	import scp_pkg::*;
(
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic PORT_SELECT_N,
	input wire logic SERIAL_CLK,
	input wire logic SERIAL_IN,
	input wire logic CLOCK_EDGE_SELECT,
	output logic SERIAL_OUT,
	output logic SERIAL_OUT_OE_N,
	output logic COMMAND_BUSY_N,
	output logic CMD_VALID,
	input wire logic CMD_READY,
	output logic [7:0] CMD_DATA,
	input wire logic REPLY_VALID,
	output logic REPLY_READY,
	input wire logic [7:0] REPLY_DATA,
	input wire logic CMD_BUSY
);
	scp_regs_t r_reg;
	scp_regs_t r_next;
	logic fifo_in_ready;
	logic sck_s;
	logic sck_rise;
	logic sck_fall;
	logic cs_active;
	logic sample_edge;
	logic launch_edge;
	logic reply_take;

	assign sck_s = r_reg.sck_sync[1];
	assign sck_rise = sck_s && !r_reg.sck_prev;
	assign sck_fall = !sck_s && r_reg.sck_prev;
	assign cs_active = !r_reg.cs_sync[1];
	// Edge selection per static edge-select level
	assign sample_edge = r_reg.edge_sync[1] ? sck_fall : sck_rise;
	assign launch_edge = r_reg.edge_sync[1] ? sck_rise : sck_fall;
	assign reply_take = r_reg.state == SCP_XFER && cs_active && launch_edge
		&& r_reg.out_cnt == SCP_BITCNT_LAST;
	assign REPLY_READY = r_reg.reply_rdy;

	always_comb begin
		r_next = r_reg;
		r_next.sck_sync = {r_reg.sck_sync[0], SERIAL_CLK};
		r_next.cs_sync = {r_reg.cs_sync[0], PORT_SELECT_N};
		r_next.si_sync = {r_reg.si_sync[0], SERIAL_IN};
		r_next.edge_sync = {r_reg.edge_sync[0], CLOCK_EDGE_SELECT};
		r_next.sck_prev = sck_s;
		r_next.busy_n = !CMD_BUSY;
		r_next.reply_rdy = reply_take && REPLY_VALID;
		if (r_reg.wr_valid && fifo_in_ready) begin
			r_next.wr_valid = 1'b0;
		end
		case (r_reg.state)
			SCP_IDLE: begin
				r_next.so_oe_n = 1'b1;
				r_next.in_cnt = SCP_BITCNT_RST;
				r_next.out_cnt = SCP_BITCNT_RST;
				if (cs_active) begin
					r_next.state = SCP_XFER;
					r_next.so_oe_n = 1'b0;
					r_next.out_shift = REPLY_VALID ? REPLY_DATA : SCP_IDLE_DATA;
					r_next.so = REPLY_VALID ? REPLY_DATA[7] : SCP_IDLE_DATA[7];
				end
			end
			SCP_XFER: begin
				if (!cs_active) begin
					r_next.state = SCP_IDLE;
					r_next.in_cnt = SCP_BITCNT_RST;
					r_next.out_cnt = SCP_BITCNT_RST;
					r_next.so_oe_n = 1'b1;
				end else begin
					if (sample_edge) begin
						r_next.in_shift = {r_reg.in_shift[6:0], r_reg.si_sync[1]};
						r_next.in_cnt = r_reg.in_cnt + 3'h1;
						if (r_reg.in_cnt == SCP_BITCNT_LAST) begin
							r_next.wr_valid = 1'b1;
							r_next.wr_data = {r_reg.in_shift[6:0], r_reg.si_sync[1]};
						end
					end
					if (launch_edge) begin
						r_next.out_cnt = r_reg.out_cnt + 3'h1;
						if (r_reg.out_cnt == SCP_BITCNT_LAST) begin
							r_next.out_shift = REPLY_VALID ? REPLY_DATA : SCP_IDLE_DATA;
							r_next.so = REPLY_VALID ? REPLY_DATA[7] : SCP_IDLE_DATA[7];
						end else begin
							r_next.out_shift = {r_reg.out_shift[6:0], 1'b1};
							r_next.so = r_reg.out_shift[6];
						end
					end
				end
			end
			default: begin
				r_next.state = SCP_IDLE;
			end
		endcase
	end

	// Reset returns everything to the idle state
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			r_reg.state <= SCP_IDLE;
			r_reg.sck_sync <= SCP_SYNC_RST;
			r_reg.cs_sync <= SCP_PIN_RST;
			r_reg.reply_rdy <= 1'b0;
			r_reg.si_sync <= SCP_SYNC_RST;
			r_reg.edge_sync <= SCP_SYNC_RST;
			r_reg.sck_prev <= 1'b0;
			r_reg.in_cnt <= SCP_BITCNT_RST;
			r_reg.in_shift <= SCP_BYTE_RST;
			r_reg.out_cnt <= SCP_BITCNT_RST;
			r_reg.out_shift <= SCP_BYTE_RST;
			r_reg.so <= 1'b1;
			r_reg.so_oe_n <= 1'b1;
			r_reg.busy_n <= 1'b1;
			r_reg.wr_valid <= 1'b0;
			r_reg.wr_data <= SCP_BYTE_RST;
		end else begin
			r_reg <= r_next;
		end
	end

	assign SERIAL_OUT = r_reg.so;
	assign SERIAL_OUT_OE_N = r_reg.so_oe_n;
	assign COMMAND_BUSY_N = r_reg.busy_n;

	scp_fifo #(
		.WIDTH(SCP_BYTE_W),
		.DEPTH(SCP_FIFO_DEPTH),
		.PW(SCP_PTR_W)
	) u_fifo (
		.clk(CLK),
		.reset_n(RESET_N),
		.in_valid(r_reg.wr_valid),
		.in_ready(fifo_in_ready),
		.in_data(r_reg.wr_data),
		.out_valid(CMD_VALID),
		.out_ready(CMD_READY),
		.out_data(CMD_DATA)
	);

	// Output released within two clocks of synced select rising
	sequence cs_rise_s;
		$rose(r_reg.cs_sync[1]);
	endsequence
	sequence oe_off_s;
		##[1:2] SERIAL_OUT_OE_N;
	endsequence
	property hiz_on_deselect_p;
		@(posedge CLK) disable iff (!RESET_N) cs_rise_s |-> oe_off_s;
	endproperty
	hiz_deselect_a: assert property (hiz_on_deselect_p)
		else $error("output not released");

	// Output driven within two clocks of synced select falling
	sequence cs_fall_s;
		$fell(r_reg.cs_sync[1]);
	endsequence
	sequence oe_on_s;
		##[1:2] !SERIAL_OUT_OE_N;
	endsequence
	property drive_on_select_p;
		@(posedge CLK) disable iff (!RESET_N) cs_fall_s |-> oe_on_s;
	endproperty
	drive_select_a: assert property (drive_on_select_p)
		else $error("output not driven");

	hiz_idle_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.cs_sync[1] && $past(r_reg.cs_sync[1]) |-> SERIAL_OUT_OE_N)
		else $error("output driven while deselected");

	// Sampling on the selected edge
	rise_sample_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_XFER && cs_active && !r_reg.edge_sync[1] && sck_rise
		|=> r_reg.in_shift[0] == $past(r_reg.si_sync[1]))
		else $error("rising edge sample missed");

	fall_sample_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_XFER && cs_active && r_reg.edge_sync[1] && sck_fall
		|=> r_reg.in_shift[0] == $past(r_reg.si_sync[1]))
		else $error("falling edge sample missed");

	byte_done_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_XFER && cs_active && sample_edge
		&& r_reg.in_cnt == SCP_BITCNT_LAST |=> r_reg.wr_valid)
		else $error("complete byte not passed on");

	// Launching on the selected edge only
	launch_low_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_XFER && !r_reg.edge_sync[1] && sck_rise |=> $stable(SERIAL_OUT))
		else $error("output moved on rising edge");

	launch_high_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_XFER && r_reg.edge_sync[1] && sck_fall |=> $stable(SERIAL_OUT))
		else $error("output moved on falling edge");

	launch_fall_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_XFER && cs_active && !r_reg.edge_sync[1] && sck_fall
		&& r_reg.out_cnt != SCP_BITCNT_LAST |=> SERIAL_OUT == $past(r_reg.out_shift[6]))
		else $error("falling edge launch missed");

	launch_rise_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_XFER && cs_active && r_reg.edge_sync[1] && sck_rise
		&& r_reg.out_cnt != SCP_BITCNT_LAST |=> SERIAL_OUT == $past(r_reg.out_shift[6]))
		else $error("rising edge launch missed");

	no_shift_idle_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_IDLE |-> r_reg.in_cnt == SCP_BITCNT_RST || !cs_active)
		else $error("bits counted outside transfer");

	deselect_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		r_reg.state == SCP_XFER && !cs_active
		|=> r_reg.in_cnt == SCP_BITCNT_RST && r_reg.out_cnt == SCP_BITCNT_RST)
		else $error("partial byte kept after deselect");

	busy_track_a: assert property (@(posedge CLK) disable iff (!RESET_N)
		CMD_BUSY |=> !COMMAND_BUSY_N)
		else $error("busy not shown");

	reset_state_a: assert property (@(posedge CLK)
		!RESET_N |=> SERIAL_OUT_OE_N && r_reg.state == SCP_IDLE)
		else $error("reset state wrong");
endmodule

/* File: scp_host.sv */
// Host model that drives serial command frames and collects reply bits
module scp_host (
	output logic select_n,
	output logic sclk,
	output logic sdi,
	output logic edge_sel,
	input wire logic sdo
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		select_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		edge_sel = 1'b0;
	end
	// Clock idles at the edge-select level, so the first toggle is the sample edge
	task automatic xfer(input logic es, input logic [7:0] tx, input int nbits,
		output logic [7:0] rx);
		rx = 8'h00;
		#100;
		edge_sel = es;
		sclk = es;
		#100;
		select_n = 1'b0;
		#60;
		for (int i = 7; i > 7 - nbits; i--) begin
			sdi = tx[i];
			#62.5;
			sclk = ~sclk;
			rx = {rx[6:0], sdo};
			#62.5;
			sclk = ~sclk;
		end
		#60;
		select_n = 1'b1;
		sdi = ~sdi;
	endtask
endmodule

/* File: tb_top.sv */
// Testbench for the serial command port front end
module tb_top
	import scp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic es; logic rv; logic [7:0] tx; logic [7:0] reply;} scp_row_t;
	scp_row_t rows[6] = '{'{1'b0, 1'b1, 8'h3C, 8'hA5}, '{1'b1, 1'b1, 8'hC3, 8'h5A},
		'{1'b0, 1'b0, 8'h81, 8'h00}, '{1'b1, 1'b0, 8'h7E, 8'h00},
		'{1'b0, 1'b1, 8'h00, 8'hFF}, '{1'b1, 1'b1, 8'hFF, 8'h01}};
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic select_n, sclk, sdi, edge_sel, so, so_oe_n, busy_n, cmd_valid, reply_ready;
	logic cmd_ready = 1'b1;
	logic reply_valid = 1'b0;
	logic cmd_busy = 1'b0;
	logic [7:0] cmd_data;
	logic [7:0] reply_data = 8'hA5;
	logic [7:0] rx;
	logic [7:0] got[$];
	int fail_count = 0;
	int compares = 0;
	int acks = 0;
	int exp_acks = 0;
	always #5 clk = ~clk;
	// Released line reads inverted so a late drive shows up
	scp_host host (.select_n(select_n), .sclk(sclk), .sdi(sdi), .edge_sel(edge_sel),
		.sdo(so_oe_n ? ~so : so));
	scp_port uut (.CLK(clk), .RESET_N(reset_n), .PORT_SELECT_N(select_n),
		.SERIAL_CLK(sclk), .SERIAL_IN(sdi), .CLOCK_EDGE_SELECT(edge_sel),
		.SERIAL_OUT(so), .SERIAL_OUT_OE_N(so_oe_n), .COMMAND_BUSY_N(busy_n),
		.CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_DATA(cmd_data),
		.REPLY_VALID(reply_valid), .REPLY_READY(reply_ready), .REPLY_DATA(reply_data),
		.CMD_BUSY(cmd_busy));
	always @(posedge clk) if (cmd_valid && cmd_ready) got.push_back(cmd_data);
	always @(posedge clk) if (reply_ready) acks++;
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic close_out();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	initial begin
		#200us;
		fail_count++;
		close_out();
	end
	initial begin
		tick(16);
		check("oe_n in reset", {7'h0, so_oe_n}, 8'h01);
		check("busy_n in reset", {7'h0, busy_n}, 8'h01);
		reset_n = 1'b1;
		tick(4);
		foreach (rows[i]) begin
			tick(1);
			reply_valid = rows[i].rv;
			reply_data = rows[i].reply;
			wait (busy_n);
			host.xfer(rows[i].es, rows[i].tx, 8, rx);
			check("reply", rx, rows[i].rv ? rows[i].reply : SCP_IDLE_DATA);
			tick(8);
			if (rows[i].rv) exp_acks++;
			check("acks", 8'(acks), 8'(exp_acks));
			check("cmd", got.pop_front(), rows[i].tx);
			check("oe_n idle", {7'h0, so_oe_n}, 8'h01);
		end
		// Partial byte is discarded when select rises
		host.xfer(1'b0, 8'hF0, 4, rx);
		host.xfer(1'b0, 8'h96, 8, rx);
		tick(8);
		check("count", 8'(got.size()), 8'h01);
		check("cmd", got.pop_front(), 8'h96);
		cmd_busy = 1'b1;
		tick(3);
		check("busy_n", {7'h0, busy_n}, 8'h00);
		cmd_busy = 1'b0;
		tick(3);
		check("busy_n", {7'h0, busy_n}, 8'h01);
		// Fill buffer and waiting stage while the consumer stalls
		cmd_ready = 1'b0;
		for (int i = 0; i < 33; i++) host.xfer(i[0], 8'(i + 16), 8, rx);
		tick(8);
		check("count", 8'(got.size()), 8'h00);
		check("valid", {7'h0, cmd_valid}, 8'h01);
		cmd_ready = 1'b1;
		tick(60);
		check("count", 8'(got.size()), 8'h21);
		for (int i = 0; i < 33; i++) check("drain", got.pop_front(), 8'(i + 16));
		check("valid", {7'h0, cmd_valid}, 8'h00);
		// Reset in mid-frame
		fork
			host.xfer(1'b0, 8'h55, 8, rx);
			begin
				tick(50);
				check("oe_n frame", {7'h0, so_oe_n}, 8'h00);
				reset_n = 1'b0;
				tick(2);
				check("oe_n reset", {7'h0, so_oe_n}, 8'h01);
				reset_n = 1'b1;
			end
		join
		tick(8);
		check("count", 8'(got.size()), 8'h00);
		host.xfer(1'b1, 8'hA5, 8, rx);
		check("reply", rx, rows[5].reply);
		tick(8);
		check("cmd", got.pop_front(), 8'hA5);
		close_out();
	end
endmodule
